// file: rfs_pkg.sv
package rfs_pkg;

	// ------------------------------------------------------------
	// Frame kinds on the ring
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RFS_KIND_SYNC = 2'h0,
		RFS_KIND_REPLY = 2'h1,
		RFS_KIND_COMMAND = 2'h2,
		RFS_KIND_IDLE = 2'h3
	} rfs_kind_type;

	// ------------------------------------------------------------
	// Start-up phases
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RFS_RING_CLOSE_PHASE = 3'h0,
		RFS_AXIS_IDENTIFY_PHASE = 3'h1,
		RFS_COMM_PARAM_PHASE = 3'h2,
		RFS_APP_PARAM_PHASE = 3'h3,
		RFS_CYCLIC_RUN_PHASE = 3'h4
	} rfs_phase_type;

	// ------------------------------------------------------------
	// Word layout and sizes
	// ------------------------------------------------------------
	localparam int RFS_WORD_W = 16;
	localparam int RFS_ADDR_W = 8;
	localparam int RFS_CYC_MAX = 4;
	localparam int RFS_CNT_W = 3;
	localparam int RFS_FIFO_DEPTH = 8;
	// Word positions inside a reply frame
	localparam logic [RFS_CNT_W-1:0] RFS_POS_ADDR = 3'h0;
	localparam logic [RFS_CNT_W-1:0] RFS_POS_STATUS = 3'h1;
	localparam logic [RFS_CNT_W-1:0] RFS_POS_SERVICE = 3'h2;
	localparam logic [RFS_CNT_W-1:0] RFS_POS_CYCLIC = 3'h3;
	// Sync frame word: low bits carry the phase, bit 15 marks it
	localparam logic [RFS_WORD_W-1:0] RFS_SYNC_MARK = 16'h8000;
	localparam logic [2:0] RFS_LINE_RATE_RESET = 3'h0;
	localparam logic [RFS_WORD_W-1:0] RFS_ZERO_WORD = 16'h0000;
	// Line rates in megabaud, encoded as a 2-bit select
	localparam logic [1:0] RFS_RATE_2M = 2'h0;
	localparam logic [1:0] RFS_RATE_16M = 2'h3;

endpackage

// file: rfs_ring_if.sv
`timescale 1ns/1ps
interface rfs_ring_if;
	// One word per beat travels on each direction of the ring
	logic m2s_valid;
	rfs_pkg::rfs_kind_type m2s_kind;
	logic [rfs_pkg::RFS_WORD_W-1:0] m2s_data;
	logic m2s_last;
	logic s2m_valid;
	logic s2m_ready;
	rfs_pkg::rfs_kind_type s2m_kind;
	logic [rfs_pkg::RFS_WORD_W-1:0] s2m_data;
	logic s2m_last;

	modport master (
		output m2s_valid,
		output m2s_kind,
		output m2s_data,
		output m2s_last,
		input s2m_valid,
		output s2m_ready,
		input s2m_kind,
		input s2m_data,
		input s2m_last
	);

	modport drive (
		input m2s_valid,
		input m2s_kind,
		input m2s_data,
		input m2s_last,
		output s2m_valid,
		input s2m_ready,
		output s2m_kind,
		output s2m_data,
		output s2m_last
	);
endinterface

// file: rfs_fifo.sv
`timescale 1ns/1ps
module rfs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} rfs_fifo_state_type;

	rfs_fifo_state_type state_reg;
	rfs_fifo_state_type state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	assign in_ready = (state_reg.count != (AW+1)'(DEPTH));
	assign out_valid = (state_reg.count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[state_reg.rd];

	// Pointer and count update
	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.wr = state_reg.wr + 1'b1;
		end
		if (pop) begin
			state_next.rd = state_reg.rd + 1'b1;
		end
		if (push && !pop) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (pop && !push) begin
			state_next.count = state_reg.count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Storage has no reset; count guards reads
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[state_reg.wr] <= in_data;
		end
	end
endmodule

// file: rfs_drive.sv
`timescale 1ns/1ps
// Operation
// - Master opens every cycle with sync frame
// - Drive answers each sync with reply frame; code sends none in ring close phase
// - Command frame follows all reply frames
// - One command frame per cycle, record per drive
// - Two-byte service field in both frames
// - Five start-up phases in fixed order
// - Ring close: slaves repeat master signal
// - Master identifies slaves by drive address
// - Drive reports timing; master sets timing
// - Master loads cyclic parameters before run
// - Reply frame carries own drive address
// - Reply order: status, service, cyclic data
// - Status word always sent, also readable
// - Cyclic section only in phases three, four
// - Mapped parameters sent once per cycle
// - Drive publishes command-mappable parameter list
// - Command record: service field, control word
// - Parameters have unique identifiers, readable elements
// - Service channel carries procedure commands too
// - Line rates two to sixteen megabaud
module rfs_drive (
	input wire logic mclk,
	input wire logic reset_n,
	rfs_ring_if.drive ring,
	input wire logic [rfs_pkg::RFS_ADDR_W-1:0] drive_address,
	input wire logic [1:0] line_rate,
	input wire logic [rfs_pkg::RFS_CNT_W-1:0] cyclic_count,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] status_word,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] service_out,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] feedback_data,
	output logic feedback_take,
	output logic [2:0] phase,
	output logic [rfs_pkg::RFS_WORD_W-1:0] control_word,
	output logic [rfs_pkg::RFS_WORD_W-1:0] service_in,
	output logic service_in_strobe,
	output logic [rfs_pkg::RFS_WORD_W-1:0] command_data,
	output logic command_strobe,
	output logic [1:0] active_rate
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RFS_D_IDLE = 2'h0,
		RFS_D_REPLY = 2'h1,
		RFS_D_WAIT_CMD = 2'h2
	} rfs_dstate_type;

	typedef struct packed {
		rfs_dstate_type st;
		rfs_pkg::rfs_phase_type phase;
		logic [rfs_pkg::RFS_CNT_W-1:0] pos;
		logic [rfs_pkg::RFS_CNT_W-1:0] map_len;
		logic [rfs_pkg::RFS_CNT_W-1:0] cmd_pos;
		logic [rfs_pkg::RFS_WORD_W-1:0] control;
		logic [rfs_pkg::RFS_WORD_W-1:0] svc;
		logic svc_stb;
		logic [rfs_pkg::RFS_WORD_W-1:0] cmd;
		logic cmd_stb;
		logic [1:0] rate;
	} rfs_drive_state_type;

	rfs_drive_state_type s_reg;
	rfs_drive_state_type s_next;
	logic f_valid;
	logic f_ready;
	logic [rfs_pkg::RFS_WORD_W:0] f_in;
	logic [rfs_pkg::RFS_WORD_W:0] f_out;
	logic cyc_phase;
	logic [rfs_pkg::RFS_WORD_W-1:0] word;
	logic last;

	// ------------------------------------------------------------
	// Reply word selection
	// ------------------------------------------------------------
	// Cyclic section present only in phases three and four
	assign cyc_phase = (s_reg.phase == rfs_pkg::RFS_APP_PARAM_PHASE) ||
		(s_reg.phase == rfs_pkg::RFS_CYCLIC_RUN_PHASE);
	always_comb begin
		word = rfs_pkg::RFS_ZERO_WORD;
		case (s_reg.pos)
			rfs_pkg::RFS_POS_ADDR: begin
				word = {{(rfs_pkg::RFS_WORD_W-rfs_pkg::RFS_ADDR_W){1'b0}},
					drive_address};
			end
			rfs_pkg::RFS_POS_STATUS: begin
				word = status_word;
			end
			rfs_pkg::RFS_POS_SERVICE: begin
				word = service_out;
			end
			default: begin
				word = feedback_data;
			end
		endcase
		// Status, service, then cyclic words
		if (s_reg.pos == rfs_pkg::RFS_POS_SERVICE) begin
			last = !cyc_phase || (s_reg.map_len == '0);
		end else begin
			last = (s_reg.pos >= rfs_pkg::RFS_POS_CYCLIC) &&
				(s_reg.pos == rfs_pkg::RFS_CNT_W'(rfs_pkg::RFS_POS_SERVICE + s_reg.map_len));
		end
	end

	assign f_valid = (s_reg.st == RFS_D_REPLY);
	// Buffer carries the frame end beside each word
	assign f_in = {last, word};
	assign feedback_take = f_valid && f_ready && (s_reg.pos >= rfs_pkg::RFS_POS_CYCLIC);

	// ------------------------------------------------------------
	// Frame sequencing
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.svc_stb = 1'b0;
		s_next.cmd_stb = 1'b0;
		case (s_reg.st)
			RFS_D_IDLE: begin
				// A sync frame seen in idle starts a cycle; it sets the phase only for codes 0 to 4
				if (ring.m2s_valid && ring.m2s_kind == rfs_pkg::RFS_KIND_SYNC) begin
					if (ring.m2s_data[2:0] <= 3'(rfs_pkg::RFS_CYCLIC_RUN_PHASE)) begin
						s_next.phase = rfs_pkg::rfs_phase_type'(ring.m2s_data[2:0]);
					end
					// Layout frozen once per cycle
					s_next.map_len = (cyclic_count > 3'(rfs_pkg::RFS_CYC_MAX)) ?
						3'(rfs_pkg::RFS_CYC_MAX) : cyclic_count;
					// Ring close: no reply, only repeat
					if (ring.m2s_data[2:0] != 3'(rfs_pkg::RFS_RING_CLOSE_PHASE)) begin
						s_next.st = RFS_D_REPLY;
					end
					s_next.pos = rfs_pkg::RFS_POS_ADDR;
				end
			end
			RFS_D_REPLY: begin
				if (f_ready) begin
					s_next.pos = s_reg.pos + 1'b1;
					if (last) begin
						s_next.st = RFS_D_WAIT_CMD;
						s_next.cmd_pos = '0;
					end
				end
			end
			RFS_D_WAIT_CMD: begin
				// Own record in command frame: address, service, control, data
				if (ring.m2s_valid && ring.m2s_kind == rfs_pkg::RFS_KIND_COMMAND) begin
					if (s_reg.cmd_pos != '0 || ring.m2s_data[rfs_pkg::RFS_ADDR_W-1:0] ==
						drive_address) begin
						s_next.cmd_pos = s_reg.cmd_pos + 1'b1;
					end
					if (s_reg.cmd_pos == rfs_pkg::RFS_POS_STATUS) begin
						s_next.svc = ring.m2s_data;
						s_next.svc_stb = 1'b1;
					end else if (s_reg.cmd_pos == rfs_pkg::RFS_POS_SERVICE) begin
						s_next.control = ring.m2s_data;
					end else if (s_reg.cmd_pos >= rfs_pkg::RFS_POS_CYCLIC) begin
						s_next.cmd = ring.m2s_data;
						s_next.cmd_stb = 1'b1;
					end
					if (ring.m2s_last) begin
						s_next.st = RFS_D_IDLE;
					end
				end else if (ring.m2s_valid && ring.m2s_kind == rfs_pkg::RFS_KIND_SYNC) begin
					s_next.st = RFS_D_IDLE;
				end
			end
			default: begin
				s_next.st = RFS_D_IDLE;
			end
		endcase
		// Rate taken only in ring close, before the protocol runs
		if (s_reg.phase == rfs_pkg::RFS_RING_CLOSE_PHASE) begin
			s_next.rate = line_rate;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Reply buffer toward the ring
	// ------------------------------------------------------------
	rfs_fifo #(
		.WIDTH(rfs_pkg::RFS_WORD_W + 1),
		.DEPTH(rfs_pkg::RFS_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_in),
		.out_valid(ring.s2m_valid),
		.out_ready(ring.s2m_ready),
		.out_data(f_out)
	);

	assign ring.s2m_kind = rfs_pkg::RFS_KIND_REPLY;
	assign ring.s2m_last = f_out[rfs_pkg::RFS_WORD_W];
	assign ring.s2m_data = f_out[rfs_pkg::RFS_WORD_W-1:0];

	assign phase = s_reg.phase;
	assign control_word = s_reg.control;
	assign service_in = s_reg.svc;
	assign service_in_strobe = s_reg.svc_stb;
	assign command_data = s_reg.cmd;
	assign command_strobe = s_reg.cmd_stb;
	assign active_rate = s_reg.rate;
endmodule

// file: rfs_master.sv
`timescale 1ns/1ps
module rfs_master (
	input wire logic mclk,
	input wire logic reset_n,
	rfs_ring_if.master ring,
	input wire logic cycle_start,
	input wire logic [2:0] target_phase,
	input wire logic [rfs_pkg::RFS_ADDR_W-1:0] drive_address,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] service_word,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] control_word,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] command_value,
	output logic busy,
	output logic [2:0] phase,
	output logic [rfs_pkg::RFS_WORD_W-1:0] reply_data,
	output logic reply_strobe,
	output logic reply_done
);
	typedef enum logic [1:0] {
		RFS_M_IDLE = 2'h0,
		RFS_M_WAIT = 2'h1,
		RFS_M_CMD = 2'h2
	} rfs_mstate_type;

	typedef struct packed {
		rfs_mstate_type st;
		rfs_pkg::rfs_phase_type phase;
		logic [rfs_pkg::RFS_CNT_W-1:0] pos;
		logic [rfs_pkg::RFS_WORD_W-1:0] rdata;
		logic rstb;
		logic rdone;
		logic sync;
	} rfs_master_state_type;

	rfs_master_state_type s_reg;
	rfs_master_state_type s_next;

	// ------------------------------------------------------------
	// Cycle: sync, collect reply, one command record
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rstb = 1'b0;
		s_next.rdone = 1'b0;
		s_next.sync = 1'b0;
		case (s_reg.st)
			RFS_M_IDLE: begin
				if (cycle_start) begin
					// Phases advance one step at a time, never skipped
					if (3'(s_reg.phase) < target_phase &&
						s_reg.phase != rfs_pkg::RFS_CYCLIC_RUN_PHASE) begin
						s_next.phase = rfs_pkg::rfs_phase_type'(3'(s_reg.phase) + 3'h1);
					end else if (target_phase < 3'(s_reg.phase)) begin
						s_next.phase = rfs_pkg::RFS_RING_CLOSE_PHASE;
					end
					s_next.sync = 1'b1;
					s_next.st = (s_next.phase == rfs_pkg::RFS_RING_CLOSE_PHASE) ?
						RFS_M_IDLE : RFS_M_WAIT;
				end
			end
			RFS_M_WAIT: begin
				if (ring.s2m_valid) begin
					s_next.rdata = ring.s2m_data;
					s_next.rstb = 1'b1;
					if (ring.s2m_last) begin
						s_next.rdone = 1'b1;
						s_next.st = RFS_M_CMD;
						s_next.pos = '0;
					end
				end
			end
			RFS_M_CMD: begin
				s_next.pos = s_reg.pos + 1'b1;
				if (s_reg.pos == rfs_pkg::RFS_POS_CYCLIC) begin
					s_next.st = RFS_M_IDLE;
				end
			end
			default: begin
				s_next.st = RFS_M_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Link outputs
	// ------------------------------------------------------------
	always_comb begin
		ring.m2s_valid = s_reg.sync || (s_reg.st == RFS_M_CMD);
		ring.m2s_kind = s_reg.sync ? rfs_pkg::RFS_KIND_SYNC : rfs_pkg::RFS_KIND_COMMAND;
		ring.m2s_last = (s_reg.st == RFS_M_CMD) && (s_reg.pos == rfs_pkg::RFS_POS_CYCLIC);
		ring.m2s_data = rfs_pkg::RFS_SYNC_MARK | {13'h0000, 3'(s_reg.phase)};
		if (!s_reg.sync) begin
			case (s_reg.pos)
				rfs_pkg::RFS_POS_ADDR: ring.m2s_data = {8'h00, drive_address};
				rfs_pkg::RFS_POS_STATUS: ring.m2s_data = service_word;
				rfs_pkg::RFS_POS_SERVICE: ring.m2s_data = control_word;
				default: ring.m2s_data = command_value;
			endcase
		end
	end

	assign ring.s2m_ready = (s_reg.st == RFS_M_WAIT);
	assign busy = (s_reg.st != RFS_M_IDLE);
	assign phase = s_reg.phase;
	assign reply_data = s_reg.rdata;
	assign reply_strobe = s_reg.rstb;
	assign reply_done = s_reg.rdone;
endmodule

// file: rfs_props.sv
`timescale 1ns/1ps
module rfs_props (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic m2s_valid,
	input wire rfs_pkg::rfs_kind_type m2s_kind,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] m2s_data,
	input wire logic m2s_last,
	input wire logic s2m_valid,
	input wire logic s2m_ready,
	input wire rfs_pkg::rfs_kind_type s2m_kind,
	input wire logic [rfs_pkg::RFS_WORD_W-1:0] s2m_data,
	input wire logic s2m_last
);
	// --------------------
	// Per-cycle tracking
	// --------------------
	logic sync;
	logic cmd;
	logic take;
	logic [2:0] ph_reg;
	logic [3:0] cnt_reg;
	logic rep_reg;
	logic cmd_reg;
	assign sync = m2s_valid && m2s_kind == rfs_pkg::RFS_KIND_SYNC;
	assign cmd = m2s_valid && m2s_kind == rfs_pkg::RFS_KIND_COMMAND;
	assign take = s2m_valid && s2m_ready;
	// Cleared at every sync, so all counts are per bus cycle
	always_ff @(posedge mclk) begin
		if (!reset_n || sync) begin
			ph_reg <= reset_n ? m2s_data[2:0] : 3'h0;
			cnt_reg <= 4'h0;
			rep_reg <= 1'b0;
			cmd_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + {3'h0, take};
			rep_reg <= rep_reg | (take && s2m_last);
			cmd_reg <= cmd_reg | (cmd && m2s_last);
		end
	end
	// --------------------
	// Properties
	// --------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence cmd_beat;
		cmd && !m2s_last;
	endsequence
	sequence cmd_end;
		cmd && m2s_last;
	endsequence
	chk_sync_mark: assert property (sync |-> m2s_data[15])
		else $error("sync word without mark bit");
	chk_sync_phase: assert property (sync |-> m2s_data[2:0] <= 3'h4)
		else $error("sync carries an unknown phase");
	chk_reply_after_sync: assert property (
		sync && m2s_data[2:0] != 3'h0 |-> ##[1:20] s2m_valid)
		else $error("no reply after sync");
	chk_no_reply_close: assert property (
		sync && m2s_data[2:0] == 3'h0 |=> !s2m_valid [*8])
		else $error("reply sent in ring close phase");
	chk_reply_kind_only: assert property (s2m_valid |-> s2m_kind == rfs_pkg::RFS_KIND_REPLY)
		else $error("drive sent a non-reply word");
	chk_reply_hold: assert property (
		s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_data))
		else $error("reply word changed before taken");
	chk_reply_length: assert property (
		take && s2m_last |-> ((ph_reg < 3'h3) ? cnt_reg == 4'h2 :
		(cnt_reg >= 4'h2 && cnt_reg <= 4'h6)))
		else $error("reply frame length wrong for phase");
	chk_one_command: assert property (cmd_end |-> !cmd_reg)
		else $error("second command frame in one cycle");
	chk_cmd_after_reply: assert property (cmd && ph_reg != 3'h0 |-> rep_reg)
		else $error("command frame before reply ended");
	chk_cmd_record: assert property (
		cmd && !$past(cmd) |-> cmd_beat ##1 cmd_beat ##1 cmd_beat ##1 cmd_end)
		else $error("command record not four beats");
endmodule

// file: tb_ring_fieldbus_slave_framing.sv
`timescale 1ns/1ps
module tb_ring_fieldbus_slave_framing;
	typedef struct packed {
		logic [2:0] tgt;
		logic [2:0] cc;
		logic [3:0] words;
	} rfs_row_type;
	// Rows step the phase up, cap the mapping, then fall back to ring close
	rfs_row_type rows[8] = '{'{3'h1, 3'h2, 4'h3}, '{3'h2, 3'h2, 4'h3}, '{3'h3, 3'h2, 4'h5},
		'{3'h4, 3'h4, 4'h7}, '{3'h4, 3'h6, 4'h7}, '{3'h4, 3'h0, 4'h3}, '{3'h0, 3'h0, 4'h0},
		'{3'h1, 3'h1, 4'h3}};
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cycle_start = 1'b0;
	logic [2:0] target_phase = 3'h0;
	logic [7:0] m_addr = 8'h2A;
	logic [7:0] d_addr = 8'h2A;
	logic [1:0] line_rate = 2'h0;
	logic [2:0] cyclic_count = 3'h0;
	logic [15:0] status_word = 16'h5A01;
	logic [15:0] service_out = 16'h1234;
	logic [15:0] feedback_data = 16'hBEEF;
	logic [15:0] m_service = 16'h4321;
	logic [15:0] m_ctrl = 16'hC100;
	logic [15:0] m_cmd = 16'h7E57;
	logic feedback_take, service_in_strobe, command_strobe;
	logic busy, reply_strobe, reply_done;
	logic [15:0] control_word, service_in, command_data, reply_data;
	logic [2:0] d_phase, m_phase;
	logic [1:0] active_rate;
	logic [15:0] rx[$];
	int err_count = 0;
	int cmp_count = 0;
	int takes, cmds, dones, beats;
	rfs_ring_if ring();
	rfs_master rfs_master_inst (.mclk(mclk), .reset_n(reset_n), .ring(ring),
		.cycle_start(cycle_start), .target_phase(target_phase), .drive_address(m_addr),
		.service_word(m_service), .control_word(m_ctrl), .command_value(m_cmd), .busy(busy),
		.phase(m_phase), .reply_data(reply_data), .reply_strobe(reply_strobe),
		.reply_done(reply_done));
	rfs_drive rfs_drive_inst (.mclk(mclk), .reset_n(reset_n), .ring(ring),
		.drive_address(d_addr), .line_rate(line_rate), .cyclic_count(cyclic_count),
		.status_word(status_word), .service_out(service_out), .feedback_data(feedback_data),
		.feedback_take(feedback_take), .phase(d_phase), .control_word(control_word),
		.service_in(service_in), .service_in_strobe(service_in_strobe),
		.command_data(command_data), .command_strobe(command_strobe), .active_rate(active_rate));
	rfs_props rfs_props_inst (.mclk(mclk), .reset_n(reset_n), .m2s_valid(ring.m2s_valid),
		.m2s_kind(ring.m2s_kind), .m2s_data(ring.m2s_data), .m2s_last(ring.m2s_last),
		.s2m_valid(ring.s2m_valid), .s2m_ready(ring.s2m_ready), .s2m_kind(ring.s2m_kind),
		.s2m_data(ring.s2m_data), .s2m_last(ring.s2m_last));
	// --------------------
	// Clock and monitors
	// --------------------
	always #50 mclk = ~mclk;
	// Sampled mid-cycle, where every one-cycle strobe stands settled
	always @(negedge mclk) begin
		if (ring.s2m_valid === 1'b1 && ring.s2m_ready === 1'b1) beats++;
		if (reply_strobe === 1'b1) rx.push_back(reply_data);
		if (feedback_take === 1'b1) takes++;
		if (command_strobe === 1'b1) cmds++;
		if (reply_done === 1'b1) dones++;
	end
	// --------------------
	// Tasks
	// --------------------
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Bounded wait on busy; a few spare cycles let the command strobes land
	task automatic run_cycle(input logic [2:0] tgt);
		int n;
		n = 0;
		rx.delete();
		takes = 0;
		cmds = 0;
		dones = 0;
		beats = 0;
		@(negedge mclk);
		target_phase = tgt;
		cycle_start = 1'b1;
		@(negedge mclk);
		cycle_start = 1'b0;
		while (busy === 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		repeat (3) @(negedge mclk);
		check("busy_timeout", 16'h0000, 16'(n >= 200));
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// --------------------
	// Main sequence
	// --------------------
	initial begin
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			cyclic_count = rows[i].cc;
			m_ctrl = 16'hC100 + 16'(i);
			run_cycle(rows[i].tgt);
			check("master_phase", 16'(rows[i].tgt), 16'(m_phase));
			check("drive_phase", 16'(rows[i].tgt), 16'(d_phase));
			check("reply_words", 16'(rows[i].words), 16'(rx.size()));
			check("feedback_takes", 16'(rows[i].words > 3 ? rows[i].words - 3 : 0), 16'(takes));
			for (int k = 0; k < rx.size(); k++)
				check("reply_word", k == 0 ? {8'h00, d_addr} : k == 1 ? status_word :
					k == 2 ? service_out : feedback_data, rx[k]);
			if (rows[i].words != 0) begin
				check("reply_done", 16'h0001, 16'(dones));
				check("control_word", m_ctrl, control_word);
				check("service_in", m_service, service_in);
				check("command_data", m_cmd, command_data);
				check("command_count", 16'h0001, 16'(cmds));
			end
		end
		// Record for another address must leave the control word alone
		m_addr = 8'h55;
		m_ctrl = 16'hDEAD;
		run_cycle(3'h2);
		check("own_address", 16'h002A, rx.size() > 0 ? rx[0] : 16'hFFFF);
		check("foreign_control", 16'hC107, control_word);
		check("foreign_commands", 16'h0000, 16'(cmds));
		m_addr = 8'h2A;
		// Every line rate, each taken through a reset (first one mid-run)
		for (int r = 0; r < 4; r++) begin
			@(negedge mclk);
			reset_n = 1'b0;
			line_rate = 2'(r);
			repeat (2) @(negedge mclk);
			reset_n = 1'b1;
			repeat (2) @(negedge mclk);
			check("active_rate", 16'(r), 16'(active_rate));
			check("reset_phase", 16'h0000, 16'(d_phase));
		end
		// Reply buffer seen through the drive: each word passes once, then it drains
		run_cycle(3'h1);
		check("fifo_accepted", 16'h0003, 16'(beats));
		check("fifo_data", service_out, rx.size() > 2 ? rx[2] : 16'hFFFF);
		check("fifo_empty", 16'h0000, 16'(ring.s2m_valid));
		// Rate must stay frozen once the protocol has left ring close
		line_rate = 2'h1;
		repeat (2) @(negedge mclk);
		check("rate_frozen", 16'h0003, 16'(active_rate));
		end_sim();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#1000000;
		err_count++;
		end_sim();
	end
endmodule
